// ### design/pmc_pkg.sv
// Constants, types and field layout of the power and message capability registers
package pmc_pkg;
  localparam logic [7:0]  OFS_PM_CTRL      = 8'h44;
  localparam logic [7:0]  OFS_MSG_CTRL     = 8'h4C;
  localparam logic [7:0]  OFS_MSG_ADDR_LO  = 8'h50;
  localparam logic [7:0]  OFS_MSG_ADDR_HI  = 8'h54;
  localparam logic [7:0]  OFS_MSG_DATA     = 8'h58;
  localparam int          POS_STATE        = 0;
  localparam int          POS_NO_SOFT_RST  = 3;
  localparam int          POS_EVT_EN       = 8;
  localparam int          POS_DATA_SEL     = 9;
  localparam int          POS_DATA_SCALE   = 13;
  localparam int          POS_EVT_STATUS   = 15;
  localparam int          POS_DATA_BYTE    = 24;
  localparam int          POS_MSG_EN       = 16;
  localparam int          POS_MULTI_EN     = 20;
  localparam int          POS_ADDR64       = 23;
  localparam logic [7:0]  MSG_CAP_ID       = 8'h05;
  localparam logic [7:0]  MSG_NEXT_PTR     = 8'h64;
  localparam logic [1:0]  ST_D0            = 2'h0;
  localparam logic [1:0]  ST_D3HOT         = 2'h3;
  localparam logic        NO_SOFT_RST_RST  = 1'h1;
  localparam logic [7:0]  DATA_BYTE_RST    = 8'h00;
  localparam logic        ADDR64_CAPABLE   = 1'h1;
  localparam logic [29:0] ADDR_LO_RST      = 30'h00000000;
  localparam logic [31:0] ADDR_HI_RST      = 32'h00000000;
  localparam logic [15:0] MSG_DATA_RST     = 16'h0000;
  localparam int          HOT_RST_NS       = 16;
  localparam int          CLK_NS           = 4;
  localparam logic [3:0]  HOT_RST_CYC      = 4'((HOT_RST_NS + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic        valid;
    logic [7:0]  offset;
    logic        write;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } pmc_cfg_req_t;

  typedef struct packed {
    logic [63:0] address;
    logic [15:0] data;
  } pmc_msg_wr_t;

  typedef enum logic [1:0] {
    PMC_MS_IDLE = 2'h0,
    PMC_MS_SEND = 2'h1,
    PMC_MS_DONE = 2'h3
  } pmc_msg_state_t;
endpackage

// ### design/pmc_hot_reset.sv
// Hot reset pulse generator for the leave-hot-off transition
`timescale 1ns/1ns
module pmc_hot_reset (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic trigger,
  output logic      hot_reset
);
  logic [3:0] count;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= 4'h0;
    end else if (clk_en) begin
      if (trigger) begin
        count <= pmc_pkg::HOT_RST_CYC;
      end else if (count != 4'h0) begin
        count <= count - 4'h1;
      end
    end
  end

  assign hot_reset = (count != 4'h0);
endmodule

// ### design/pmc_msg_writer.sv
// Issues message memory writes on interrupt requests; requests that arrive while one is pending merge into one write
`timescale 1ns/1ns
module pmc_msg_writer (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 enable,
  input  wire logic                 request,
  input  wire pmc_pkg::pmc_msg_wr_t target,
  output pmc_pkg::pmc_msg_wr_t      wr,
  output logic                      wr_valid,
  input  wire logic                 wr_ready
);
  pmc_pkg::pmc_msg_state_t state;
  pmc_pkg::pmc_msg_state_t next_state;
  logic                    pending;

  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_MS_IDLE: if (enable && (request || pending)) next_state = pmc_pkg::PMC_MS_SEND;
      pmc_pkg::PMC_MS_SEND: if (wr_ready) next_state = pmc_pkg::PMC_MS_DONE;
      pmc_pkg::PMC_MS_DONE: next_state = pmc_pkg::PMC_MS_IDLE;
      default:              next_state = pmc_pkg::PMC_MS_IDLE;
    endcase
  end

  // Request arriving mid-write is held, not lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state   <= pmc_pkg::PMC_MS_IDLE;
      pending <= 1'b0;
      wr      <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (request && state != pmc_pkg::PMC_MS_IDLE) begin
        pending <= 1'b1;
      end else if (next_state == pmc_pkg::PMC_MS_SEND && state == pmc_pkg::PMC_MS_IDLE) begin
        pending <= 1'b0;
      end
      if (state == pmc_pkg::PMC_MS_IDLE && next_state == pmc_pkg::PMC_MS_SEND) begin
        wr <= target;
      end
    end
  end

  assign wr_valid = (state == pmc_pkg::PMC_MS_SEND);

  a_one_write_each: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_valid && wr_ready && clk_en) |=> !wr_valid)
    else $error("message write repeated");
  a_write_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(wr_valid)) |-> $past(enable))
    else $error("message write while disabled");
endmodule

// ### design/pmc_regs.sv
// Power management control and message interrupt capability register bank
`timescale 1ns/1ns
module pmc_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire pmc_pkg::pmc_cfg_req_t cfg_req,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rvalid,
  input  wire logic                  is_downstream,
  input  wire logic                  strap_load,
  input  wire logic                  strap_no_soft_reset,
  input  wire logic [7:0]            strap_data_byte,
  input  wire logic                  port_irq,
  output logic [1:0]                 power_state,
  output logic                       power_event_msg_enable,
  output logic                       internal_reset,
  output logic                       downstream_reset_out_n,
  output logic                       legacy_irq_n,
  output pmc_pkg::pmc_msg_wr_t       msg_wr,
  output logic                       msg_wr_valid,
  input  wire logic                  msg_wr_ready
);
  logic [1:0]  pm_state;
  logic        no_soft_reset;
  logic        evt_en;
  logic [3:0]  data_sel;
  logic [7:0]  data_byte;
  logic        interrupt_message_enable;
  logic [2:0]  multi_en;
  logic [29:0] addr_lo;
  logic [31:0] addr_hi;
  logic [15:0] msg_data;
  logic        hot_reset;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  wire logic        wr_any   = cfg_req.valid && cfg_req.write && clk_en;
  wire logic        hit_pm   = (cfg_req.offset == pmc_pkg::OFS_PM_CTRL);
  // Message block exists only on downstream ports
  wire logic        hit_mc   = is_downstream && (cfg_req.offset == pmc_pkg::OFS_MSG_CTRL);
  wire logic        hit_alo  = is_downstream && (cfg_req.offset == pmc_pkg::OFS_MSG_ADDR_LO);
  wire logic        hit_ahi  = is_downstream && (cfg_req.offset == pmc_pkg::OFS_MSG_ADDR_HI);
  wire logic        hit_dat  = is_downstream && (cfg_req.offset == pmc_pkg::OFS_MSG_DATA);

  // Power word: bridge bits and event status held at zero
  wire logic [31:0] pm_word  = {data_byte, 8'h00, 1'b0, 2'b00, data_sel, evt_en, 4'h0,
                                no_soft_reset, 1'b0, pm_state};
  wire logic [31:0] mc_word  = {8'h00, pmc_pkg::ADDR64_CAPABLE, multi_en, 3'b000, interrupt_message_enable,
                                pmc_pkg::MSG_NEXT_PTR, pmc_pkg::MSG_CAP_ID};
  wire logic [31:0] alo_word = {addr_lo, 2'b00};
  wire logic [31:0] dat_word = {16'h0000, msg_data};

  wire logic [31:0] pm_new   = merge_bytes(pm_word, cfg_req.wdata, cfg_req.byte_en);
  wire logic [31:0] mc_new   = merge_bytes(mc_word, cfg_req.wdata, cfg_req.byte_en);
  wire logic [31:0] alo_new  = merge_bytes(alo_word, cfg_req.wdata, cfg_req.byte_en);
  wire logic [31:0] ahi_new  = merge_bytes(addr_hi, cfg_req.wdata, cfg_req.byte_en);
  wire logic [31:0] dat_new  = merge_bytes(dat_word, cfg_req.wdata, cfg_req.byte_en);

  wire logic        pm_wr    = wr_any && hit_pm;
  wire logic [1:0]  st_new   = pm_new[pmc_pkg::POS_STATE +: 2];
  wire logic        leave_d3 = pm_wr && (pm_state == pmc_pkg::ST_D3HOT) && (st_new == pmc_pkg::ST_D0);
  // Suppression flag decides whether the hot reset happens at all
  wire logic        do_reset = leave_d3 && !no_soft_reset;

  // Config-space control; a hot reset returns it to defaults
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pm_state                 <= pmc_pkg::ST_D0;
      data_sel                 <= 4'h0;
      interrupt_message_enable <= 1'b0;
      multi_en                 <= 3'b000;
      addr_lo                  <= pmc_pkg::ADDR_LO_RST;
      addr_hi                  <= pmc_pkg::ADDR_HI_RST;
      msg_data                 <= pmc_pkg::MSG_DATA_RST;
    end else if (clk_en) begin
      if (hot_reset) begin
        pm_state                 <= pmc_pkg::ST_D0;
        data_sel                 <= 4'h0;
        interrupt_message_enable <= 1'b0;
        multi_en                 <= 3'b000;
        addr_lo                  <= pmc_pkg::ADDR_LO_RST;
        addr_hi                  <= pmc_pkg::ADDR_HI_RST;
        msg_data                 <= pmc_pkg::MSG_DATA_RST;
      end else if (cfg_req.valid && cfg_req.write) begin
        if (hit_pm) begin
          pm_state <= st_new;
          data_sel <= pm_new[pmc_pkg::POS_DATA_SEL +: 4];
        end
        if (hit_mc) begin
          interrupt_message_enable <= mc_new[pmc_pkg::POS_MSG_EN];
          multi_en                 <= mc_new[pmc_pkg::POS_MULTI_EN +: 3];
        end
        if (hit_alo) addr_lo <= alo_new[31:2];
        if (hit_ahi) addr_hi <= ahi_new;
        if (hit_dat) msg_data <= dat_new[15:0];
      end
    end
  end

  // Sticky enable survives hot reset; cleared by rst_n or by a power-word write of 0
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_en <= 1'b0;
    end else if (clk_en && pm_wr && !hot_reset) begin
      evt_en <= pm_new[pmc_pkg::POS_EVT_EN];
    end
  end

  // Strap values caught after reset release, never under reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      no_soft_reset <= pmc_pkg::NO_SOFT_RST_RST;
      data_byte     <= pmc_pkg::DATA_BYTE_RST;
    end else if (clk_en && strap_load) begin
      no_soft_reset <= strap_no_soft_reset;
      data_byte     <= strap_data_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (clk_en) begin
      cfg_rvalid <= cfg_req.valid && !cfg_req.write;
      cfg_rdata  <= hit_pm  ? pm_word  :
                    hit_mc  ? mc_word  :
                    hit_alo ? alo_word :
                    hit_ahi ? addr_hi  :
                    hit_dat ? dat_word : 32'h00000000;
    end
  end

  pmc_hot_reset u_hot_reset (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .trigger   (do_reset),
    .hot_reset (hot_reset)
  );

  // Upper word counts only when 64-bit addressing is advertised
  wire pmc_pkg::pmc_msg_wr_t target = '{
    address: {pmc_pkg::ADDR64_CAPABLE ? addr_hi : 32'h00000000, addr_lo, 2'b00},
    data:    msg_data};

  pmc_msg_writer u_msg_writer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .enable   (interrupt_message_enable && is_downstream),
    .request  (port_irq && interrupt_message_enable),
    .target   (target),
    .wr       (msg_wr),
    .wr_valid (msg_wr_valid),
    .wr_ready (msg_wr_ready)
  );

  assign power_state            = pm_state;
  assign power_event_msg_enable = evt_en;
  assign internal_reset         = hot_reset;
  assign downstream_reset_out_n = 1'b1;
  // Legacy line silenced whenever messages are enabled
  assign legacy_irq_n           = !(port_irq && !interrupt_message_enable);

  a_hot_reset_fires: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && do_reset) |=> internal_reset)
    else $error("hot reset missing on leaving hot-off");
  a_no_soft_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && leave_d3 && no_soft_reset && !internal_reset) |=> !internal_reset)
    else $error("reset performed while suppressed");
  a_dwn_reset_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    internal_reset |-> downstream_reset_out_n)
    else $error("downstream reset driven during hot reset");
  a_state_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && pm_wr && !hot_reset && !do_reset) |=> power_state == $past(st_new))
    else $error("power state not written");
  a_status_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg_rvalid && $past(hit_pm)) |-> (cfg_rdata[15] == 1'b0 && cfg_rdata[23:22] == 2'b00))
    else $error("hardwired power bits nonzero");
  a_cap_header: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg_rvalid && $past(hit_mc)) |-> (cfg_rdata[15:0] == 16'h6405 && cfg_rdata[23]))
    else $error("message header wrong");
  a_addr_aligned: assert property (@(posedge clk_sys) disable iff (!rst_n)
    msg_wr_valid |-> (msg_wr.address[1:0] == 2'b00))
    else $error("message address not aligned");
  a_evt_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!pm_wr) |=> (power_event_msg_enable == $past(power_event_msg_enable)))
    else $error("event enable changed without write");
  a_legacy_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    interrupt_message_enable |-> legacy_irq_n)
    else $error("legacy interrupt while messaging");
  a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!clk_en) |=> (power_state == $past(power_state) && cfg_rdata == $past(cfg_rdata)))
    else $error("state changed while clock enable low");
endmodule

// ### sim/pmc_msg_sink.sv
// Host-side acceptor of message memory writes, prompt or slow
`timescale 1ns/1ns
module pmc_msg_sink (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 slow,
  input  wire pmc_pkg::pmc_msg_wr_t msg_wr,
  input  wire logic                 msg_wr_valid,
  output logic                      msg_wr_ready,
  output int                        wr_cnt,
  output pmc_pkg::pmc_msg_wr_t      last_wr
);
  int wait_cyc;
  // Ready only while a write is offered; slow mode stalls 3 cycles
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      msg_wr_ready <= 1'b0;
      wr_cnt       <= 0;
      wait_cyc     <= 0;
      last_wr      <= '0;
    end else if (msg_wr_valid && msg_wr_ready) begin
      msg_wr_ready <= 1'b0;
      wr_cnt       <= wr_cnt + 1;
      last_wr      <= msg_wr;
      wait_cyc     <= 0;
    end else if (msg_wr_valid) begin
      msg_wr_ready <= (wait_cyc >= (slow ? 3 : 0));
      wait_cyc     <= wait_cyc + 1;
    end else begin
      msg_wr_ready <= 1'b0;
      wait_cyc     <= 0;
    end
  end
endmodule

// ### sim/pmc_regs_bench.sv
// Self-checking bench for the power and message capability registers
`timescale 1ns/1ns
module pmc_regs_bench;
  logic                  clk_sys = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  clk_en = 1'b1;
  pmc_pkg::pmc_cfg_req_t cfg_req = '0;
  logic [31:0]           cfg_rdata;
  logic                  cfg_rvalid;
  logic                  is_dn = 1'b1;
  logic                  strap_load = 1'b0;
  logic                  strap_nsr = 1'b1;
  logic [7:0]            strap_byte = 8'h00;
  logic                  port_irq = 1'b0;
  logic [1:0]            power_state;
  logic                  evt_en;
  logic                  int_rst;
  logic                  dn_rst_n;
  logic                  legacy_irq_n;
  pmc_pkg::pmc_msg_wr_t  msg_wr;
  logic                  msg_wr_valid;
  logic                  msg_wr_ready;
  logic                  slow = 1'b0;
  int                    wr_cnt;
  pmc_pkg::pmc_msg_wr_t  last_wr;
  int                    error_cnt = 0;
  int                    num_checks = 0;
  int                    cyc = 0;

  always #2 clk_sys = ~clk_sys;

  pmc_regs pmc_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .is_downstream(is_dn), .strap_load(strap_load),
    .strap_no_soft_reset(strap_nsr), .strap_data_byte(strap_byte), .port_irq(port_irq),
    .power_state(power_state), .power_event_msg_enable(evt_en), .internal_reset(int_rst),
    .downstream_reset_out_n(dn_rst_n), .legacy_irq_n(legacy_irq_n), .msg_wr(msg_wr),
    .msg_wr_valid(msg_wr_valid), .msg_wr_ready(msg_wr_ready));

  pmc_msg_sink pmc_msg_sink_inst (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .msg_wr(msg_wr),
    .msg_wr_valid(msg_wr_valid), .msg_wr_ready(msg_wr_ready), .wr_cnt(wr_cnt), .last_wr(last_wr));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs under 120 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg_wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
    tick(1);
    cfg_req = '{valid: 1'b1, offset: ofs, write: 1'b1, byte_en: be, wdata: d};
    tick(1);
    cfg_req.valid = 1'b0;
  endtask

  // Read data only counts when the answer pulse stands in that cycle
  task automatic rd_chk(input string n, input logic [7:0] ofs, input logic [31:0] e);
    tick(1);
    cfg_req = '{valid: 1'b1, offset: ofs, write: 1'b0, byte_en: 4'hF, wdata: 32'h0};
    tick(1);
    cfg_req.valid = 1'b0;
    chk(n, e, (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hXXXXXXXX);
  endtask

  task automatic chk_rst(input string n, input int e);
    int hi;
    logic dn_ok;
    hi = 0;
    dn_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      hi += (int_rst === 1'b1);
      dn_ok &= (dn_rst_n === 1'b1);
      tick(1);
    end
    chk(n, 32'(e), 32'(hi));
    chk("dn_reset_held", 32'h1, {31'h0, dn_ok});
  endtask

  task automatic t_reset_vals();
    rd_chk("pm_reset", pmc_pkg::OFS_PM_CTRL, 32'h00000008);
    rd_chk("msg_hdr", pmc_pkg::OFS_MSG_CTRL, 32'h00806405);
    rd_chk("addr_lo", pmc_pkg::OFS_MSG_ADDR_LO, 32'h0);
    rd_chk("addr_hi", pmc_pkg::OFS_MSG_ADDR_HI, 32'h0);
    rd_chk("unmapped", 8'h60, 32'h0);
    $display("test reset_vals done");
  endtask

  task automatic t_pm_write();
    cfg_wr(pmc_pkg::OFS_PM_CTRL, 4'hF, 32'hFFFFFFFF);
    rd_chk("pm_ones", pmc_pkg::OFS_PM_CTRL, 32'h00001F0B);
    chk("state", 32'h3, {30'h0, power_state});
    chk("evt_en", 32'h1, {31'h0, evt_en});
    cfg_wr(pmc_pkg::OFS_PM_CTRL, 4'h1, 32'h0);
    chk_rst("no_soft_rst", 0);
    rd_chk("pm_d0", pmc_pkg::OFS_PM_CTRL, 32'h00001F08);
    $display("test pm_write done");
  endtask

  task automatic t_hot_reset();
    strap_load = 1'b1;
    strap_nsr = 1'b0;
    strap_byte = 8'hA5;
    tick(1);
    strap_load = 1'b0;
    rd_chk("pm_straps", pmc_pkg::OFS_PM_CTRL, 32'hA5001F00);
    cfg_wr(pmc_pkg::OFS_PM_CTRL, 4'h1, 32'h3);
    cfg_wr(pmc_pkg::OFS_PM_CTRL, 4'h1, 32'h0);
    chk_rst("hot_rst_len", int'(pmc_pkg::HOT_RST_CYC));
    rd_chk("pm_after", pmc_pkg::OFS_PM_CTRL, 32'hA5000100);
    $display("test hot_reset done");
  endtask

  task automatic t_message();
    cfg_wr(pmc_pkg::OFS_MSG_ADDR_LO, 4'hF, 32'h12345677);
    cfg_wr(pmc_pkg::OFS_MSG_ADDR_HI, 4'hF, 32'hCAFE0001);
    cfg_wr(pmc_pkg::OFS_MSG_DATA, 4'hF, 32'hFFFF1234);
    rd_chk("addr_lo", pmc_pkg::OFS_MSG_ADDR_LO, 32'h12345674);
    rd_chk("addr_hi", pmc_pkg::OFS_MSG_ADDR_HI, 32'hCAFE0001);
    rd_chk("msg_data", pmc_pkg::OFS_MSG_DATA, 32'h00001234);
    port_irq = 1'b1;
    tick(6);
    chk("legacy_irq", 32'h0, {31'h0, legacy_irq_n});
    chk("no_msg", 32'h0, 32'(wr_cnt));
    port_irq = 1'b0;
    cfg_wr(pmc_pkg::OFS_MSG_CTRL, 4'h4, 32'h00010000);
    rd_chk("msg_ctrl", pmc_pkg::OFS_MSG_CTRL, 32'h00816405);
    slow = 1'b1;
    port_irq = 1'b1;
    #1;
    chk("legacy_off", 32'h1, {31'h0, legacy_irq_n});
    tick(1);
    port_irq = 1'b0;
    tick(20);
    chk("msg_count", 32'h1, 32'(wr_cnt));
    chk("msg_addr_hi", 32'hCAFE0001, last_wr.address[63:32]);
    chk("msg_addr_lo", 32'h12345674, last_wr.address[31:0]);
    chk("msg_payload", 32'h1234, {16'h0, last_wr.data});
    slow = 1'b0;
    port_irq = 1'b1;
    tick(1);
    port_irq = 1'b0;
    tick(10);
    chk("msg_prompt", 32'h2, 32'(wr_cnt));
    $display("test message done");
  endtask

  task automatic t_upstream();
    is_dn = 1'b0;
    cfg_wr(pmc_pkg::OFS_MSG_ADDR_HI, 4'hF, 32'h55AA55AA);
    rd_chk("up_hdr", pmc_pkg::OFS_MSG_CTRL, 32'h0);
    rd_chk("up_addr_hi", pmc_pkg::OFS_MSG_ADDR_HI, 32'h0);
    is_dn = 1'b1;
    rd_chk("up_wr_refused", pmc_pkg::OFS_MSG_ADDR_HI, 32'hCAFE0001);
    $display("test upstream done");
  endtask

  // Write offered while frozen must not land
  task automatic t_freeze();
    clk_en = 1'b0;
    cfg_wr(pmc_pkg::OFS_MSG_DATA, 4'hF, 32'h0000BEEF);
    clk_en = 1'b1;
    rd_chk("frozen_wr", pmc_pkg::OFS_MSG_DATA, 32'h00001234);
    $display("test freeze done");
  endtask

  initial begin
    tick(4);
    rst_n = 1'b1;
    t_reset_vals();
    t_pm_write();
    t_hot_reset();
    t_message();
    t_freeze();
    t_upstream();
    end_sim();
  end
endmodule
